// File: zts_consts.svh
// Purpose: Constants for the zone tracking status input image
// Assumes: 25 MHz clock, 16-bit registers at their module addresses
// Notes:   Included by every design file of the block except the package and the interface
//
// Contract
// - Upstream held carton's two tracking words shown while it sits stopped
// - Downstream held carton's two tracking words shown while it sits stopped
// - Each zone's release command register value is mirrored for reading
// - Forward discharge to unmanaged conveyor captures words into forward pair
// - Reverse discharge to unmanaged conveyor captures words into reverse pair
// - Sensor bits: 0 left aux, 2 right aux, 4 left sensor, 6 right
// - Sensor bit 15 is a heartbeat, 2 s high then 2 s low
// - Sensor bits read 1 when blocked, 0 when clear, any sensor type
// - Per-port polarity comes from the initial automatic configuration; here it is relatched at every autoCfgDone strobe
// - Stop bit 5 for group stop, bit 6 for lost communication
// - Stop bit 7 lost host, bit 10 host command, rest reserved zero
// - Word after sensor register is reserved and carries no status
`ifndef ZTS_CONSTS_SVH
`define ZTS_CONSTS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ZTS_ADR_STOP      8'h13
`define ZTS_ADR_SENSOR    8'h23
`define ZTS_ADR_UP_REL    8'h69
`define ZTS_ADR_UP_TRK1   8'h77
`define ZTS_ADR_UP_TRK2   8'h78
`define ZTS_ADR_REV_TRK1  8'h79
`define ZTS_ADR_REV_TRK2  8'h7a
`define ZTS_ADR_DN_REL    8'hb9
`define ZTS_ADR_DN_TRK1   8'hc7
`define ZTS_ADR_DN_TRK2   8'hc8
`define ZTS_ADR_FWD_TRK1  8'hc9
`define ZTS_ADR_FWD_TRK2  8'hca

// ****************************************************************
// Byte image: word count, byte index width and word indices
// ****************************************************************
`define ZTS_IMG_WORDS     21
`define ZTS_IMG_BYTE_W    6
`define ZTS_IMG_UP_TRK1   5'd8
`define ZTS_IMG_SENSOR    5'd18
`define ZTS_IMG_RSVD      5'd19
`define ZTS_IMG_STOP      5'd20

// ****************************************************************
// Field positions
// ****************************************************************
`define ZTS_SEN_LAUX      0
`define ZTS_SEN_RAUX      2
`define ZTS_SEN_LSEN      4
`define ZTS_SEN_RSEN      6
`define ZTS_SEN_BEAT      15
`define ZTS_STP_GROUP     5
`define ZTS_STP_COMM      6
`define ZTS_STP_HOST      7
`define ZTS_STP_CMD       10
`define ZTS_RST_WORD      16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ZTS_CLK_HZ        25000000
`define ZTS_BEAT_SEC      2
`define ZTS_BEAT_CYC      (`ZTS_BEAT_SEC * `ZTS_CLK_HZ)

`endif

// File: zts_pkg.sv
// Purpose: Types for the zone tracking status input image
// Assumes: Nothing beyond the constants header
// Notes:   Holds types only
package zts_pkg;
  typedef logic [15:0] zts_word_t;
  typedef enum logic [1:0] {
    ZTS_IDLE    = 2'b00,
    ZTS_HELD    = 2'b01,
    ZTS_LEFT    = 2'b10
  } zts_zone_t;
endpackage

// File: zts_capture_if.sv
// Purpose: Carrier between top and the tracking capture pair
// Assumes: One clock
// Notes:   Top drives load side, capture module shows the words
`timescale 1ns/1ps
interface zts_capture_if;
  logic              load;
  zts_pkg::zts_word_t word1In;
  zts_pkg::zts_word_t word2In;
  zts_pkg::zts_word_t word1;
  zts_pkg::zts_word_t word2;
  modport src (output load, output word1In, output word2In,
               input word1, input word2);
  modport dst (input load, input word1In, input word2In,
               output word1, output word2);
endinterface

// File: zts_word_pair.sv
// Purpose: Holds a pair of tracking words, loaded together
// Assumes: Load is a one-cycle pulse
// Notes:   Both words load on the same edge so a read is coherent
`include "zts_consts.svh"
`timescale 1ns/1ps
module zts_word_pair (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Capture
  zts_capture_if.dst cap
);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cap.word1 <= `ZTS_RST_WORD;
      cap.word2 <= `ZTS_RST_WORD;
    end else if (cap.load) begin
      cap.word1 <= cap.word1In;
      cap.word2 <= cap.word2In;
    end
  end
endmodule

// File: zts_heartbeat.sv
// Purpose: Heartbeat level, 2 s high and 2 s low
// Assumes: 25 MHz clock
// Notes:   Half-period count is a parameter so simulation can shorten it
`include "zts_consts.svh"
`timescale 1ns/1ps
module zts_heartbeat #(
  parameter int unsigned HALF_CYC = `ZTS_BEAT_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Beat
  output logic      beat
);
  logic [26:0] count;
  wire         wrap = (count == 27'(HALF_CYC - 1));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 27'h0000000;
      beat  <= 1'b1;
    end else begin
      count <= wrap ? 27'h0000000 : count + 27'h0000001;
      if (wrap) begin
        beat <= ~beat;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_beat_steady;
    @(posedge clock) disable iff (sys_rst)
      !wrap |=> $stable(beat);
  endproperty
  a_beat_steady: assert property (p_beat_steady)
    else $error("heartbeat changed before its half period");

  property p_beat_flip;
    @(posedge clock) disable iff (sys_rst)
      wrap |=> (beat != $past(beat));
  endproperty
  a_beat_flip: assert property (p_beat_flip)
    else $error("heartbeat did not toggle at half period");
endmodule

// File: zts_status_inputs.sv
// Purpose: Read-only input image of a conveyor zone controller
// Assumes: Zone events arrive as one-cycle pulses; inputs synchronous
// Notes:   Word reads by module address; byte reads by image index
`include "zts_consts.svh"
`timescale 1ns/1ps
module zts_status_inputs #(
  parameter int unsigned BEAT_HALF_CYC = `ZTS_BEAT_CYC
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // Zone carton state
  input  wire logic                upHeld,
  input  wire zts_pkg::zts_word_t  upTrk1,
  input  wire zts_pkg::zts_word_t  upTrk2,
  input  wire logic                dnHeld,
  input  wire zts_pkg::zts_word_t  dnTrk1,
  input  wire zts_pkg::zts_word_t  dnTrk2,
  // Discharge to unmanaged conveyor
  input  wire logic                dischargeUnmanaged,
  input  wire logic                reverseDir,
  // Release command output registers
  input  wire zts_pkg::zts_word_t  upReleaseCmd,
  input  wire zts_pkg::zts_word_t  dnReleaseCmd,
  // Sensor port raw lines
  input  wire logic                leftAuxRaw,
  input  wire logic                rightAuxRaw,
  input  wire logic                leftSensorRaw,
  input  wire logic                rightSensorRaw,
  // Auto-configuration polarity, 1 means raw high when clear
  input  wire logic                autoCfgDone,
  input  wire logic [3:0]          cfgInvert,
  // Stop causes
  input  wire logic                stopGroup,
  input  wire logic                stopCommLost,
  input  wire logic                stopHostLost,
  input  wire logic                stopHostCmd,
  // Word read port
  input  wire logic [7:0]          regAddr,
  output zts_pkg::zts_word_t       regData,
  output logic                     regHit,
  // Byte image read port
  input  wire logic [5:0]          imgByte,
  output logic [7:0]               imgData
);

  // ****************************************************************
  // Held carton words
  // ****************************************************************
  zts_pkg::zts_word_t upWord1;
  zts_pkg::zts_word_t upWord2;
  zts_pkg::zts_word_t dnWord1;
  zts_pkg::zts_word_t dnWord2;

  // Both words load together so the pair never shows a mix
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      upWord1 <= `ZTS_RST_WORD;
      upWord2 <= `ZTS_RST_WORD;
    end else if (upHeld) begin
      upWord1 <= upTrk1;
      upWord2 <= upTrk2;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dnWord1 <= `ZTS_RST_WORD;
      dnWord2 <= `ZTS_RST_WORD;
    end else if (dnHeld) begin
      dnWord1 <= dnTrk1;
      dnWord2 <= dnTrk2;
    end
  end

  // ****************************************************************
  // Discharge capture
  // ****************************************************************
  zts_capture_if fwdCap ();
  zts_capture_if revCap ();

  // Direction steers the capture into one pair only
  assign fwdCap.load    = dischargeUnmanaged & ~reverseDir;
  assign revCap.load    = dischargeUnmanaged & reverseDir;
  assign fwdCap.word1In = dnTrk1;
  assign fwdCap.word2In = dnTrk2;
  assign revCap.word1In = dnTrk1;
  assign revCap.word2In = dnTrk2;

  zts_word_pair u_fwd (
    .clock   (clock),
    .sys_rst (sys_rst),
    .cap     (fwdCap)
  );

  zts_word_pair u_rev (
    .clock   (clock),
    .sys_rst (sys_rst),
    .cap     (revCap)
  );

  // ****************************************************************
  // Release count mirrors
  // ****************************************************************
  zts_pkg::zts_word_t upRelMirror;
  zts_pkg::zts_word_t dnRelMirror;

  // Host reads this copy back before writing a new release count, without comparing it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      upRelMirror <= `ZTS_RST_WORD;
      dnRelMirror <= `ZTS_RST_WORD;
    end else begin
      upRelMirror <= upReleaseCmd;
      dnRelMirror <= dnReleaseCmd;
    end
  end

  // ****************************************************************
  // Sensor port bits
  // ****************************************************************
  logic [3:0] polarity;
  logic [3:0] portBits;
  logic       beat;
  wire  [3:0] rawLines = {rightSensorRaw, leftSensorRaw,
                          rightAuxRaw, leftAuxRaw};

  // Polarity is latched at each auto-configuration strobe, not per sample
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      polarity <= 4'h0;
    end else if (autoCfgDone) begin
      polarity <= cfgInvert;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      portBits <= 4'h0;
    end else begin
      portBits <= rawLines ^ polarity;
    end
  end

  zts_heartbeat #(
    .HALF_CYC (BEAT_HALF_CYC)
  ) u_beat (
    .clock   (clock),
    .sys_rst (sys_rst),
    .beat    (beat)
  );

  zts_pkg::zts_word_t sensorWord;
  always_comb begin
    sensorWord                 = 16'h0000;
    sensorWord[`ZTS_SEN_LAUX]  = portBits[0];
    sensorWord[`ZTS_SEN_RAUX]  = portBits[1];
    sensorWord[`ZTS_SEN_LSEN]  = portBits[2];
    sensorWord[`ZTS_SEN_RSEN]  = portBits[3];
    sensorWord[`ZTS_SEN_BEAT]  = beat;
  end

  // ****************************************************************
  // Stop cause word
  // ****************************************************************
  zts_pkg::zts_word_t stopWord;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stopWord <= `ZTS_RST_WORD;
    end else begin
      stopWord                 <= 16'h0000;
      stopWord[`ZTS_STP_GROUP] <= stopGroup;
      stopWord[`ZTS_STP_COMM]  <= stopCommLost;
      stopWord[`ZTS_STP_HOST]  <= stopHostLost;
      stopWord[`ZTS_STP_CMD]   <= stopHostCmd;
    end
  end

  // ****************************************************************
  // Word read decode
  // ****************************************************************
  wire hitStop = (regAddr == `ZTS_ADR_STOP);
  wire hitSen  = (regAddr == `ZTS_ADR_SENSOR);
  wire hitUpR  = (regAddr == `ZTS_ADR_UP_REL);
  wire hitUp1  = (regAddr == `ZTS_ADR_UP_TRK1);
  wire hitUp2  = (regAddr == `ZTS_ADR_UP_TRK2);
  wire hitRv1  = (regAddr == `ZTS_ADR_REV_TRK1);
  wire hitRv2  = (regAddr == `ZTS_ADR_REV_TRK2);
  wire hitDnR  = (regAddr == `ZTS_ADR_DN_REL);
  wire hitDn1  = (regAddr == `ZTS_ADR_DN_TRK1);
  wire hitDn2  = (regAddr == `ZTS_ADR_DN_TRK2);
  wire hitFw1  = (regAddr == `ZTS_ADR_FWD_TRK1);
  wire hitFw2  = (regAddr == `ZTS_ADR_FWD_TRK2);
  wire anyHit  = hitStop | hitSen | hitUpR | hitUp1 | hitUp2 | hitRv1 |
                 hitRv2 | hitDnR | hitDn1 | hitDn2 | hitFw1 | hitFw2;

  wire [15:0] wordSel =
      ({16{hitStop}} & stopWord)      | ({16{hitSen}} & sensorWord)  |
      ({16{hitUpR}}  & upRelMirror)   | ({16{hitUp1}} & upWord1)     |
      ({16{hitUp2}}  & upWord2)       | ({16{hitRv1}} & revCap.word1)|
      ({16{hitRv2}}  & revCap.word2)  | ({16{hitDnR}} & dnRelMirror) |
      ({16{hitDn1}}  & dnWord1)       | ({16{hitDn2}} & dnWord2)     |
      ({16{hitFw1}}  & fwdCap.word1)  | ({16{hitFw2}} & fwdCap.word2);

  // Unmapped addresses read zero with regHit low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regData <= `ZTS_RST_WORD;
      regHit  <= 1'b0;
    end else begin
      regData <= wordSel;
      regHit  <= anyHit;
    end
  end

  // ****************************************************************
  // Byte image, high byte first
  // ****************************************************************
  // Image words 0..7 (zone status, counts, module status) are not
  // held here and read zero.
  zts_pkg::zts_word_t image [`ZTS_IMG_WORDS];
  always_comb begin
    for (int i = 0; i < `ZTS_IMG_WORDS; i++) begin
      image[i] = 16'h0000;
    end
    image[8]  = upWord1;
    image[9]  = upWord2;
    image[10] = dnWord1;
    image[11] = dnWord2;
    image[12] = upRelMirror;
    image[13] = dnRelMirror;
    image[14] = fwdCap.word1;
    image[15] = fwdCap.word2;
    image[16] = revCap.word1;
    image[17] = revCap.word2;
    image[18] = sensorWord;
    image[19] = 16'h0000;
    image[20] = stopWord;
  end

  wire [4:0]  imgWord  = imgByte[5:1];
  wire        imgValid = (imgWord < 5'(`ZTS_IMG_WORDS));
  wire [15:0] imgSel   = imgValid ? image[imgWord] : 16'h0000;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      imgData <= 8'h00;
    end else begin
      imgData <= imgByte[0] ? imgSel[7:0] : imgSel[15:8];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Configuration strobe followed by a quiet cycle
  sequence s_cfg_load;
    autoCfgDone ##1 !autoCfgDone;
  endsequence

  property p_up_words;
    @(posedge clock) disable iff (sys_rst)
      upHeld |=> (upWord1 == $past(upTrk1)) && (upWord2 == $past(upTrk2));
  endproperty
  a_up_words: assert property (p_up_words)
    else $error("upstream held words not shown");

  property p_dn_words;
    @(posedge clock) disable iff (sys_rst)
      dnHeld |=> (dnWord1 == $past(dnTrk1)) && (dnWord2 == $past(dnTrk2));
  endproperty
  a_dn_words: assert property (p_dn_words)
    else $error("downstream held words not shown");

  property p_rel_mirror;
    @(posedge clock) disable iff (sys_rst)
      ##1 (upRelMirror == $past(upReleaseCmd)) &&
          (dnRelMirror == $past(dnReleaseCmd));
  endproperty
  a_rel_mirror: assert property (p_rel_mirror)
    else $error("release mirror stale");

  property p_fwd_cap;
    @(posedge clock) disable iff (sys_rst)
      (dischargeUnmanaged && !reverseDir) |=>
        (fwdCap.word1 == $past(dnTrk1)) && $stable(revCap.word1);
  endproperty
  a_fwd_cap: assert property (p_fwd_cap)
    else $error("forward capture wrong");

  property p_rev_cap;
    @(posedge clock) disable iff (sys_rst)
      (dischargeUnmanaged && reverseDir) |=>
        (revCap.word2 == $past(dnTrk2)) && $stable(fwdCap.word2);
  endproperty
  a_rev_cap: assert property (p_rev_cap)
    else $error("reverse capture wrong");

  property p_sensor_map;
    @(posedge clock) disable iff (sys_rst)
      (sensorWord & 16'h7faa) == 16'h0000;
  endproperty
  a_sensor_map: assert property (p_sensor_map)
    else $error("reserved sensor bit set");

  property p_blocked;
    @(posedge clock) disable iff (sys_rst)
      s_cfg_load |=> portBits == ($past(rawLines) ^ $past(cfgInvert, 2));
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("sensor polarity not applied");

  property p_stop_bits;
    @(posedge clock) disable iff (sys_rst)
      stopHostCmd && stopGroup |=>
        stopWord[`ZTS_STP_CMD] && stopWord[`ZTS_STP_GROUP] &&
        ((stopWord & 16'hfb1f) == 16'h0000);
  endproperty
  a_stop_bits: assert property (p_stop_bits)
    else $error("stop cause word wrong");

  property p_byte_order;
    @(posedge clock) disable iff (sys_rst)
      (imgByte == 6'h10) |=> (imgData == $past(upWord1[15:8]));
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("byte 16 is not high byte of upstream word 1");
endmodule

// File: zts_plc_model.sv
// Purpose: Host poller model for the status input image
// Assumes: Word answer one edge after the address is taken
// Notes:   Owns the release command registers it mirrors
`include "zts_consts.svh"
`timescale 1ns/1ps
module zts_plc_model (
  // Clock
  input  wire logic               clock,
  // Word read port
  output logic [7:0]              regAddr,
  input  wire zts_pkg::zts_word_t regData,
  input  wire logic               regHit,
  // Release command registers
  output zts_pkg::zts_word_t      upReleaseCmd,
  output zts_pkg::zts_word_t      dnReleaseCmd
);
  // ****************************************
  // Host tasks
  // ****************************************
  initial begin
    regAddr      = 8'h00;
    upReleaseCmd = 16'h0000;
    dnReleaseCmd = 16'h0000;
  end

  // Address stays put until the answer edge has passed
  task automatic read_word(input logic [7:0] a,
                           output zts_pkg::zts_word_t d,
                           output logic h);
    @(posedge clock);
    regAddr <= a;
    @(posedge clock);
    @(posedge clock);
    d = regData;
    h = regHit;
  endtask

  // Mirror read first and returned in seen; the new count is written whatever it holds
  task automatic write_release(input logic up,
                               input zts_pkg::zts_word_t v,
                               output zts_pkg::zts_word_t seen);
    logic h;
    read_word(up ? `ZTS_ADR_UP_REL : `ZTS_ADR_DN_REL, seen, h);
    @(posedge clock);
    if (up) begin
      upReleaseCmd <= v;
    end else begin
      dnReleaseCmd <= v;
    end
  endtask
endmodule

// File: tb_zone_tracking_status_inputs.sv
// Purpose: Self-checking bench for the status input image
// Assumes: Heartbeat half period shortened to HALF cycles
// Notes:   Word reads go through the poller model, but t_beat samples regData directly each cycle; byte image reads drive imgByte directly
`include "zts_consts.svh"
`timescale 1ns/1ps
module tb_zone_tracking_status_inputs;
  localparam int unsigned HALF = 8;
  logic               clock = 1'b0;
  logic               sys_rst = 1'b1;
  logic               upHeld = 1'b0;
  logic               dnHeld = 1'b0;
  logic               dischargeUnmanaged = 1'b0;
  logic               reverseDir = 1'b0;
  logic               autoCfgDone = 1'b0;
  logic [3:0]         cfgInvert = 4'h0;
  logic [3:0]         raw = 4'h0;
  logic [3:0]         stopV = 4'h0;
  logic [5:0]         imgByte = 6'h00;
  zts_pkg::zts_word_t upTrk1 = 16'h0000;
  zts_pkg::zts_word_t upTrk2 = 16'h0000;
  zts_pkg::zts_word_t dnTrk1 = 16'h0000;
  zts_pkg::zts_word_t dnTrk2 = 16'h0000;
  zts_pkg::zts_word_t upRel;
  zts_pkg::zts_word_t dnRel;
  zts_pkg::zts_word_t regData;
  logic [7:0]         regAddr;
  logic [7:0]         imgData;
  logic               regHit;
  int                 num_errors = 0;
  int                 checked = 0;

  always #20 clock = ~clock;

  zts_plc_model plc (.clock(clock), .regAddr(regAddr),
    .regData(regData), .regHit(regHit),
    .upReleaseCmd(upRel), .dnReleaseCmd(dnRel));

  zts_status_inputs #(.BEAT_HALF_CYC(HALF)) uut (
    .clock(clock), .sys_rst(sys_rst), .upHeld(upHeld),
    .upTrk1(upTrk1), .upTrk2(upTrk2), .dnHeld(dnHeld),
    .dnTrk1(dnTrk1), .dnTrk2(dnTrk2),
    .dischargeUnmanaged(dischargeUnmanaged),
    .reverseDir(reverseDir), .upReleaseCmd(upRel),
    .dnReleaseCmd(dnRel), .leftAuxRaw(raw[0]),
    .rightAuxRaw(raw[1]), .leftSensorRaw(raw[2]),
    .rightSensorRaw(raw[3]), .autoCfgDone(autoCfgDone),
    .cfgInvert(cfgInvert), .stopGroup(stopV[0]),
    .stopCommLost(stopV[1]), .stopHostLost(stopV[2]),
    .stopHostCmd(stopV[3]), .regAddr(regAddr),
    .regData(regData), .regHit(regHit),
    .imgByte(imgByte), .imgData(imgData));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [15:0] exp);
    zts_pkg::zts_word_t d;
    logic h;
    plc.read_word(a, d, h);
    check(n, d, exp);
    check({n, " hit"}, {15'h0000, h}, 16'h0001);
  endtask

  task automatic rdByte(input logic [5:0] i, input logic [7:0] exp);
    @(posedge clock);
    imgByte <= i;
    @(posedge clock);
    @(posedge clock);
    check("image byte", {8'h00, imgData}, {8'h00, exp});
  endtask

  task automatic tick;
    @(posedge clock);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd("fwd word1 reset", `ZTS_ADR_FWD_TRK1, 16'h0000);
    rd("sensor at start", `ZTS_ADR_SENSOR, 16'h8000);
  endtask

  task automatic t_held;
    tick();
    upHeld <= 1'b1;
    dnHeld <= 1'b1;
    upTrk1 <= 16'ha1b2;
    upTrk2 <= 16'hc3d4;
    dnTrk1 <= 16'he5f6;
    dnTrk2 <= 16'h0789;
    tick();
    upHeld <= 1'b0;
    dnHeld <= 1'b0;
    upTrk1 <= 16'h5555;
    dnTrk2 <= 16'h6666;
    rd("up word1", `ZTS_ADR_UP_TRK1, 16'ha1b2);
    rd("up word2", `ZTS_ADR_UP_TRK2, 16'hc3d4);
    rd("dn word1", `ZTS_ADR_DN_TRK1, 16'he5f6);
    rd("dn word2", `ZTS_ADR_DN_TRK2, 16'h0789);
  endtask

  task automatic t_release;
    zts_pkg::zts_word_t s;
    plc.write_release(1'b1, 16'h0005, s);
    check("up mirror before", s, 16'h0000);
    plc.write_release(1'b0, 16'h0102, s);
    check("dn mirror before", s, 16'h0000);
    plc.write_release(1'b1, 16'h0006, s);
    check("up mirror after", s, 16'h0005);
    rd("dn mirror", `ZTS_ADR_DN_REL, 16'h0102);
  endtask

  task automatic t_discharge;
    tick();
    dnTrk1 <= 16'h1111;
    dnTrk2 <= 16'h2222;
    dischargeUnmanaged <= 1'b1;
    tick();
    dnTrk1 <= 16'h3333;
    dnTrk2 <= 16'h4444;
    reverseDir <= 1'b1;
    tick();
    dischargeUnmanaged <= 1'b0;
    rd("fwd word1", `ZTS_ADR_FWD_TRK1, 16'h1111);
    rd("fwd word2", `ZTS_ADR_FWD_TRK2, 16'h2222);
    rd("rev word1", `ZTS_ADR_REV_TRK1, 16'h3333);
    rd("rev word2", `ZTS_ADR_REV_TRK2, 16'h4444);
  endtask

  task automatic t_sensor;
    logic [3:0] inv;
    logic [3:0] b;
    zts_pkg::zts_word_t e;
    zts_pkg::zts_word_t d;
    logic h;
    for (int k = 0; k < 2; k++) begin
      inv = (k == 0) ? 4'h0 : 4'h5;
      tick();
      cfgInvert <= inv;
      autoCfgDone <= 1'b1;
      tick();
      autoCfgDone <= 1'b0;
      cfgInvert <= ~inv;
      for (int r = 0; r < 16; r += 5) begin
        raw <= r[3:0];
        b = r[3:0] ^ inv;
        plc.read_word(`ZTS_ADR_SENSOR, d, h);
        e = {9'h000, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
        check("sensor bits", d & 16'h7fff, e);
      end
    end
  endtask

  task automatic t_beat;
    zts_pkg::zts_word_t d;
    logic h;
    logic prev;
    int run;
    int runs;
    int ones;
    run = 0;
    runs = 0;
    ones = 0;
    plc.read_word(`ZTS_ADR_SENSOR, d, h);
    prev = d[15];
    for (int i = 0; i < 4 * HALF; i++) begin
      @(posedge clock);
      if (regData[15] !== prev) begin
        if (runs > 0) check("beat run", run[15:0], 16'(HALF));
        runs++;
        run = 0;
        prev = regData[15];
      end
      run++;
      ones += (regData[15] === 1'b1);
    end
    check("beat high count", ones[15:0], 16'(2 * HALF));
  endtask

  task automatic t_stop;
    int pos [4] = '{5, 6, 7, 10};
    for (int i = 0; i < 4; i++) begin
      stopV <= 4'h1 << i;
      rd("stop", `ZTS_ADR_STOP, 16'h0001 << pos[i]);
    end
    stopV <= 4'hf;
    rd("stop all", `ZTS_ADR_STOP, 16'h04e0);
  endtask

  task automatic t_image;
    zts_pkg::zts_word_t d;
    logic h;
    rdByte(6'd16, 8'ha1);
    rdByte(6'd17, 8'hb2);
    rdByte(6'd38, 8'h00);
    rdByte(6'd39, 8'h00);
    rdByte(6'd40, 8'h04);
    rdByte(6'd41, 8'he0);
    plc.read_word(8'h00, d, h);
    check("unmapped data", d, 16'h0000);
    check("unmapped hit", {15'h0000, h}, 16'h0000);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_held();
    t_release();
    t_discharge();
    t_sensor();
    t_beat();
    t_stop();
    t_image();
    final_report();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    final_report();
  end
endmodule
